// File: dsm_line_bank.sv
// dsm_line_bank: fifteen digital lines with servo and square-wave functions
// assumes pad logic resolves pin level from line_out, line_oe_n and pull_dn
//
// Contract
// - fifteen lines 0..14, each configured and controlled by software
// - every line offers input, output and high impedance
// - code 0 input, 1 output, 4 high impedance, 5 input with pull-down
// - code 2 servo in, 3 servo out, 6 wave out, 7 wave in
// - output mode drives the last written level
// - input mode reads the sampled pin level
// - high impedance drops drive and pull; level writes have no effect
// - servo input only on lines 0-3, servo output only on 4-7
// - four servo input channels and four servo output channels
// - servo output: 20 ms frame starting with 1-2 ms high pulse; the code does not clamp the pulse to 1-2 ms
// - servo input measures high-pulse length as position
// - line 4 wave input only; lines 5-8 wave input and output
// - five wave input channels and four wave output channels
// - wave output period and high time follow programmed values
// - wave channel 0 sits on line 4, next channels on next lines
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module dsm_line_bank
	import dsm_pkg::*;
#(
	parameter int unsigned NUM_LINES = 15,
	parameter int unsigned FRAME_CYC = SERVO_FRAME_CYC
) (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// pins
	input  wire logic [14:0] line_in,
	output logic      [14:0] line_out,
	output logic      [14:0] line_oe_n,
	output logic      [14:0] pull_dn
);

	localparam int unsigned CW = 32;

	initial begin
		if (NUM_LINES != 15)
			$error("dsm_line_bank serves exactly 15 lines");
		if (FRAME_CYC <= SERVO_MAX_CYC)
			$error("servo frame must exceed the longest pulse");
	end

	// mode legality for a line
	function automatic logic mode_ok(input logic [2:0] m, input int unsigned l);
		case (dsm_mode_e'(m))
			DSM_MODE_SERVO_IN:  mode_ok = SERVO_IN_LINES[l];
			DSM_MODE_SERVO_OUT: mode_ok = SERVO_OUT_LINES[l];
			DSM_MODE_WAVE_IN:   mode_ok = WAVE_IN_LINES[l];
			DSM_MODE_WAVE_OUT:  mode_ok = WAVE_OUT_LINES[l];
			default:            mode_ok = 1'b1;
		endcase
	endfunction

	// register index inside a block of eight words
	function automatic int unsigned word_idx(input logic [11:0] a);
		word_idx = int'(a[4:2]);
	endfunction

	// ---- state ----
	logic [2:0]  mode_reg [15];
	logic [2:0]  mode_next [15];
	logic [14:0] lvl_reg, lvl_next;
	logic [3:0]  sen_reg, sen_next;     // servo out enables, channels 4-7
	logic [3:0]  sin_en_reg, sin_en_next; // servo in enables, channels 0-3
	logic [4:0]  wen_reg, wen_next;     // wave enables: out bits 1-4 valid
	logic [4:0]  win_en_reg, win_en_next;
	logic [CW-1:0] pos_reg [8];
	logic [CW-1:0] pos_next [8];
	logic [CW-1:0] wper_reg [5], wper_next [5];
	logic [CW-1:0] whi_reg [5], whi_next [5];
	logic [CW-1:0] mper_reg [5], mper_next [5];
	logic [CW-1:0] mhi_reg [5], mhi_next [5];
	logic [CW-1:0] sfc_reg [4], sfc_next [4];   // servo out frame counter
	logic [CW-1:0] icnt_reg [4], icnt_next [4]; // servo in high counter
	logic [CW-1:0] wcnt_reg [5], wcnt_next [5]; // wave out phase counter
	logic [CW-1:0] mc_reg [5], mc_next [5];     // wave in period counter
	logic [CW-1:0] mh_reg [5], mh_next [5];     // wave in high counter
	logic [14:0] pin_prev_reg, pin_prev_next;
	logic [14:0] pin_reg, pin_next;
	logic [14:0] out_reg, out_next;
	logic [14:0] oen_reg, oen_next;
	logic [14:0] pd_reg, pd_next;
	logic [31:0] rd_reg, rd_next;
	logic        rdy_reg, rdy_next;
	logic        err_reg, err_next;

	logic        wr_acc;
	logic [14:0] alt_drive;
	int unsigned ln;

	assign wr_acc = psel && penable && pwrite && !rdy_reg;

	// ---- next-state logic ----
	always_comb begin
		for (int i = 0; i < 15; i++)
			mode_next[i] = mode_reg[i];
		lvl_next = lvl_reg;
		sen_next = sen_reg;
		sin_en_next = sin_en_reg;
		wen_next = wen_reg;
		win_en_next = win_en_reg;
		pos_next = pos_reg;
		wper_next = wper_reg;
		whi_next = whi_reg;
		mper_next = mper_reg;
		mhi_next = mhi_reg;
		sfc_next = sfc_reg;
		icnt_next = icnt_reg;
		wcnt_next = wcnt_reg;
		mc_next = mc_reg;
		mh_next = mh_reg;
		alt_drive = 15'h0000;
		ln = 0;
		pin_next = line_in;
		pin_prev_next = pin_reg;
		rdy_next = psel && penable && !rdy_reg;
		err_next = 1'b0;
		rd_next = rd_reg;

		// bus writes
		if (wr_acc) begin
			case (paddr & 12'hFE0)
				12'h000: begin
					if (paddr == OFS_MODE0 || paddr == OFS_MODE1) begin
						for (int i = 0; i < 8; i++) begin
							ln = (paddr == OFS_MODE1) ? i + 8 : i;
							if (ln < 15 && mode_ok(pwdata[i*4 +: 3], ln))
								mode_next[ln] = pwdata[i*4 +: 3];
						end
					end else if (paddr == OFS_LEVEL_OUT) begin
						for (int i = 0; i < 15; i++)
							if (mode_reg[i] != DSM_MODE_HIZ)
								lvl_next[i] = pwdata[i];
					end else if (paddr == OFS_SERVO_EN) begin
						sin_en_next = pwdata[3:0];
						sen_next = pwdata[7:4];
					end else if (paddr == OFS_WAVE_EN) begin
						win_en_next = pwdata[4:0];
						wen_next = {pwdata[12:9], 1'b0};
					end else if (paddr != OFS_LEVEL_IN)
						err_next = 1'b1;
				end
				OFS_SERVO_POS: begin
					if (word_idx(paddr) >= 4)
						pos_next[word_idx(paddr)] = pwdata;
					else
						err_next = 1'b1;
				end
				OFS_WAVE_PER: begin
					if (word_idx(paddr) < 5)
						wper_next[word_idx(paddr)] = pwdata;
					else
						err_next = 1'b1;
				end
				OFS_WAVE_HIGH: begin
					if (word_idx(paddr) < 5)
						whi_next[word_idx(paddr)] = pwdata;
					else
						err_next = 1'b1;
				end
				default: err_next = 1'b1;
			endcase
		end

		// bus reads
		if (psel && penable && !pwrite && !rdy_reg) begin
			rd_next = 32'h00000000;
			case (paddr & 12'hFE0)
				12'h000: begin
					if (paddr == OFS_MODE0)
						for (int i = 0; i < 8; i++)
							rd_next[i*4 +: 3] = mode_reg[i];
					else if (paddr == OFS_MODE1)
						for (int i = 0; i < 7; i++)
							rd_next[i*4 +: 3] = mode_reg[i+8];
					else if (paddr == OFS_LEVEL_OUT)
						rd_next[14:0] = lvl_reg;
					else if (paddr == OFS_LEVEL_IN)
						rd_next[14:0] = pin_reg;
					else if (paddr == OFS_SERVO_EN)
						rd_next[7:0] = {sen_reg, sin_en_reg};
					else if (paddr == OFS_WAVE_EN)
						rd_next[12:0] = {wen_reg[4:1], 4'h0, win_en_reg};
					else
						err_next = 1'b1;
				end
				OFS_SERVO_POS: rd_next = pos_reg[word_idx(paddr)];
				OFS_WAVE_PER,
				OFS_WAVE_HIGH,
				OFS_WMEAS_PER,
				OFS_WMEAS_HIGH: begin
					if (word_idx(paddr) >= 5)
						err_next = 1'b1;
					else if ((paddr & 12'hFE0) == OFS_WAVE_PER)
						rd_next = wper_reg[word_idx(paddr)];
					else if ((paddr & 12'hFE0) == OFS_WAVE_HIGH)
						rd_next = whi_reg[word_idx(paddr)];
					else if ((paddr & 12'hFE0) == OFS_WMEAS_PER)
						rd_next = mper_reg[word_idx(paddr)];
					else
						rd_next = mhi_reg[word_idx(paddr)];
				end
				default: err_next = 1'b1;
			endcase
		end

		// servo channels
		for (int c = 0; c < 4; c++) begin
			// output channel c+4 on line c+4
			if (sen_reg[c] && mode_reg[SERVO_OUT_BASE+c] == DSM_MODE_SERVO_OUT) begin
				sfc_next[c] = (sfc_reg[c] >= FRAME_CYC - 1) ? '0 : sfc_reg[c] + 1;
				alt_drive[SERVO_OUT_BASE+c] = sfc_reg[c] < pos_reg[c+4];
			end else
				sfc_next[c] = '0;
			// input channel c on line c
			if (sin_en_reg[c] && mode_reg[SERVO_IN_BASE+c] == DSM_MODE_SERVO_IN) begin
				if (pin_reg[c])
					icnt_next[c] = icnt_reg[c] + 1;
				else if (pin_prev_reg[c]) begin
					pos_next[c] = icnt_reg[c];
					icnt_next[c] = '0;
				end
			end else
				icnt_next[c] = '0;
		end

		// square-wave channels
		for (int c = 0; c < 5; c++) begin
			ln = WAVE_BASE + c;
			if (wen_reg[c] && mode_reg[ln] == DSM_MODE_WAVE_OUT) begin
				wcnt_next[c] = (wcnt_reg[c] + 1 >= wper_reg[c]) ? '0 : wcnt_reg[c] + 1;
				alt_drive[ln] = wcnt_reg[c] < whi_reg[c];
			end else
				wcnt_next[c] = '0;
			if (win_en_reg[c] && mode_reg[ln] == DSM_MODE_WAVE_IN) begin
				mc_next[c] = mc_reg[c] + 1;
				mh_next[c] = mh_reg[c] + (pin_reg[ln] ? 1 : 0);
				if (pin_reg[ln] && !pin_prev_reg[ln]) begin
					mper_next[c] = mc_reg[c];
					mhi_next[c] = mh_reg[c];
					mc_next[c] = 1;
					mh_next[c] = 1;
				end
			end else begin
				mc_next[c] = '0;
				mh_next[c] = '0;
			end
		end
	end

	// ---- pin drive ----
	always_comb begin
		for (int i = 0; i < 15; i++) begin
			out_next[i] = 1'b0;
			oen_next[i] = 1'b1;
			pd_next[i] = 1'b0;
			case (dsm_mode_e'(mode_reg[i]))
				DSM_MODE_OUT: begin
					out_next[i] = lvl_reg[i];
					oen_next[i] = 1'b0;
				end
				DSM_MODE_SERVO_OUT,
				DSM_MODE_WAVE_OUT: begin
					out_next[i] = alt_drive[i];
					oen_next[i] = 1'b0;
				end
				DSM_MODE_IN_PD: pd_next[i] = 1'b1;
				DSM_MODE_HIZ:   pd_next[i] = 1'b0;
				default:        pd_next[i] = 1'b0;
			endcase
		end
	end

	// ---- registers ----
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			for (int i = 0; i < 15; i++)
				mode_reg[i] <= DSM_MODE_IN;
			for (int i = 0; i < 8; i++)
				pos_reg[i] <= RST_SERVO_POS;
			for (int i = 0; i < 5; i++) begin
				wper_reg[i] <= '0;
				whi_reg[i] <= '0;
				mper_reg[i] <= '0;
				mhi_reg[i] <= '0;
				wcnt_reg[i] <= '0;
				mc_reg[i] <= '0;
				mh_reg[i] <= '0;
			end
			for (int i = 0; i < 4; i++) begin
				sfc_reg[i] <= '0;
				icnt_reg[i] <= '0;
			end
			lvl_reg <= RST_LEVEL;
			sen_reg <= 4'h0;
			sin_en_reg <= 4'h0;
			wen_reg <= 5'h00;
			win_en_reg <= 5'h00;
			pin_reg <= 15'h0000;
			pin_prev_reg <= 15'h0000;
			out_reg <= 15'h0000;
			oen_reg <= 15'h7FFF;
			pd_reg <= 15'h0000;
			rd_reg <= 32'h00000000;
			rdy_reg <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			pos_reg <= pos_next;
			wper_reg <= wper_next;
			whi_reg <= whi_next;
			mper_reg <= mper_next;
			mhi_reg <= mhi_next;
			wcnt_reg <= wcnt_next;
			mc_reg <= mc_next;
			mh_reg <= mh_next;
			sfc_reg <= sfc_next;
			icnt_reg <= icnt_next;
			lvl_reg <= lvl_next;
			sen_reg <= sen_next;
			sin_en_reg <= sin_en_next;
			wen_reg <= wen_next;
			win_en_reg <= win_en_next;
			pin_reg <= pin_next;
			pin_prev_reg <= pin_prev_next;
			out_reg <= out_next;
			oen_reg <= oen_next;
			pd_reg <= pd_next;
			rd_reg <= rd_next;
			rdy_reg <= rdy_next;
			err_reg <= err_next;
		end
	end

	assign prdata = rd_reg;
	assign pready = rdy_reg;
	assign pslverr = err_reg;
	assign line_out = out_reg;
	assign line_oe_n = oen_reg;
	assign pull_dn = pd_reg;

endmodule : dsm_line_bank
`default_nettype wire

// File: dsm_pkg.sv
// dsm_pkg: register map, mode codes and timing constants for the line bank
// assumes a 125 MHz core clock and an APB slave with 32-bit data
package dsm_pkg;

	localparam int unsigned CLK_HZ = 125000000;

	// mode codes
	typedef enum logic [2:0] {
		DSM_MODE_IN       = 3'h0,
		DSM_MODE_OUT      = 3'h1,
		DSM_MODE_SERVO_IN = 3'h2,
		DSM_MODE_SERVO_OUT = 3'h3,
		DSM_MODE_HIZ      = 3'h4,
		DSM_MODE_IN_PD    = 3'h5,
		DSM_MODE_WAVE_OUT = 3'h6,
		DSM_MODE_WAVE_IN  = 3'h7
	} dsm_mode_e;

	// servo timing
	localparam int unsigned SERVO_FRAME_US = 20000;
	localparam int unsigned SERVO_MIN_US   = 1000;
	localparam int unsigned SERVO_MAX_US   = 2000;
	localparam int unsigned SERVO_FRAME_CYC = SERVO_FRAME_US * (CLK_HZ / 1000000);
	localparam int unsigned SERVO_MIN_CYC   = SERVO_MIN_US * (CLK_HZ / 1000000);
	localparam int unsigned SERVO_MAX_CYC   = SERVO_MAX_US * (CLK_HZ / 1000000);

	// line positions of alternate functions
	localparam int unsigned SERVO_IN_BASE  = 0;
	localparam int unsigned SERVO_OUT_BASE = 4;
	localparam int unsigned WAVE_BASE      = 4;
	localparam logic [14:0] SERVO_IN_LINES  = 15'h000F;
	localparam logic [14:0] SERVO_OUT_LINES = 15'h00F0;
	localparam logic [14:0] WAVE_IN_LINES   = 15'h01F0;
	localparam logic [14:0] WAVE_OUT_LINES  = 15'h01E0;

	// register byte offsets
	localparam logic [11:0] OFS_MODE0      = 12'h000;
	localparam logic [11:0] OFS_MODE1      = 12'h004;
	localparam logic [11:0] OFS_LEVEL_OUT  = 12'h008;
	localparam logic [11:0] OFS_LEVEL_IN   = 12'h00C;
	localparam logic [11:0] OFS_SERVO_EN   = 12'h010;
	localparam logic [11:0] OFS_WAVE_EN    = 12'h014;
	localparam logic [11:0] OFS_SERVO_POS  = 12'h020;
	localparam logic [11:0] OFS_WAVE_PER   = 12'h040;
	localparam logic [11:0] OFS_WAVE_HIGH  = 12'h060;
	localparam logic [11:0] OFS_WMEAS_PER  = 12'h080;
	localparam logic [11:0] OFS_WMEAS_HIGH = 12'h0A0;

	// reset values
	localparam logic [14:0] RST_LEVEL      = 15'h0000;
	localparam logic [31:0] RST_SERVO_POS  = 32'h0001E848;

endpackage : dsm_pkg

// File: dsm_line_bank_properties.sv
// dsm_line_bank_properties: port-level checks of the line bank
// assumes a bind onto dsm_line_bank, one clock domain
`timescale 1ns/10ps
`default_nettype none
module dsm_line_bank_chk
	import dsm_pkg::*;
#(
	parameter int unsigned NUM_LINES = 15,
	parameter int unsigned FRAME_CYC = SERVO_FRAME_CYC
) (
	// clock and reset
	input wire logic        core_clk,
	input wire logic        sys_rst,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// pins
	input wire logic [14:0] line_out,
	input wire logic [14:0] line_oe_n,
	input wire logic [14:0] pull_dn
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence s_wait;
		psel && penable && !pready;
	endsequence
	sequence s_done;
		pready ##1 !pready;
	endsequence
	a_wait_then_ready: assert property (s_wait |=> s_done)
		else $error("access not answered after one wait state");
	a_ready_has_cause: assert property (pready |-> $past(psel && penable))
		else $error("ready without access phase");
	a_error_with_ready: assert property (pslverr |-> pready)
		else $error("error outside ready cycle");
	a_rdata_holds: assert property ($changed(prdata) |-> pready)
		else $error("read data moved between reads");
	a_pull_released: assert property ((pull_dn & ~line_oe_n) == 15'h0000)
		else $error("pull-down on a driven line");
	a_oe_by_write: assert property ($changed(line_oe_n) |->
		$past(psel && pwrite, 1) || $past(psel && pwrite, 2))
		else $error("drive enable moved without a write");
	a_plain_lines: assert property ($changed(line_out[14:9]) |->
		$past(psel && pwrite, 1) || $past(psel && pwrite, 2))
		else $error("plain line level moved without a write");
	a_reset_state: assert property (disable iff (1'b0) sys_rst |=>
		line_oe_n == 15'h7FFF && pull_dn == 15'h0000 && !pready)
		else $error("outputs not idle after reset");
endmodule // dsm_line_bank_chk
bind dsm_line_bank dsm_line_bank_chk #(
	.NUM_LINES(NUM_LINES),
	.FRAME_CYC(FRAME_CYC)
) dsm_line_bank_chk_inst (
	.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.line_out(line_out), .line_oe_n(line_oe_n), .pull_dn(pull_dn)
);
`default_nettype wire

// File: dsm_pin_model.sv
// dsm_pin_model: pin-side circuits, resolves each line's level
// assumes active-low drive enable and a pull-down per line
`timescale 1ns/10ps
`default_nettype none
module dsm_pin_model (
	// clock
	input  wire logic        core_clk,
	// device side
	input  wire logic [14:0] line_out,
	input  wire logic [14:0] line_oe_n,
	input  wire logic [14:0] pull_dn,
	// outside drivers
	input  wire logic [14:0] ext_drv,
	input  wire logic [14:0] ext_val,
	input  wire logic        sq_en,
	input  wire logic [7:0]  sq_per,
	input  wire logic [7:0]  sq_high,
	// resolved level
	output logic      [14:0] line_in
);
	logic [7:0]  cnt_reg   = 8'h00;
	logic [14:0] float_reg = 15'h5555;
	always_ff @(posedge core_clk) begin
		cnt_reg   <= (cnt_reg + 8'h01 >= sq_per) ? 8'h00 : cnt_reg + 8'h01;
		float_reg <= ~float_reg;
	end
	always_comb begin
		for (int i = 0; i < 15; i++) begin
			if (!line_oe_n[i])
				line_in[i] = line_out[i];
			else if (ext_drv[i])
				line_in[i] = ext_val[i];
			else if (pull_dn[i])
				line_in[i] = 1'b0;
			else
				line_in[i] = float_reg[i];
		end
		if (sq_en && line_oe_n[4])
			line_in[4] = (cnt_reg < sq_high);
	end
endmodule // dsm_pin_model
`default_nettype wire

// File: tb_top.sv
// tb_top: register-level tests of the line bank over apb
// assumes dsm_pin_model on the pins and the checker bound in
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import dsm_pkg::*;
;
	logic        core_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic        sq_en, ok, rd_err;
	logic [11:0] paddr, ma;
	logic [31:0] pwdata, prdata, rd_q;
	logic [14:0] line_in, line_out, line_oe_n, pull_dn, ext_drv, ext_val;
	logic [7:0]  sq_per, sq_high;
	int          miscompares, checks, cyc = 0, sh, pv, hi, lo;

	dsm_line_bank dsm_line_bank_inst (.core_clk(core_clk), .sys_rst(sys_rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.line_in(line_in), .line_out(line_out), .line_oe_n(line_oe_n),
		.pull_dn(pull_dn));
	dsm_pin_model dsm_pin_model_inst (.core_clk(core_clk), .line_out(line_out),
		.line_oe_n(line_oe_n), .pull_dn(pull_dn), .ext_drv(ext_drv),
		.ext_val(ext_val), .sq_en(sq_en), .sq_per(sq_per), .sq_high(sq_high),
		.line_in(line_in));

	task automatic end_of_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		rd_q    = prdata;
		rd_err  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		cmp(nm, e, rd_q);
	endtask

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			miscompares++;
			end_of_test();
		end
	end

	initial begin
		{sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
		{ext_drv, ext_val, sq_en, sq_per, sq_high} = {31'h0, 8'h14, 8'h07};
		{miscompares, checks} = {32'h0, 32'h0};
		repeat (8) @(posedge core_clk);
		sys_rst <= 1'b0;
		cmp("oe_n reset", 32'h7FFF, {17'h0, line_oe_n});
		rdc("servo pos reset", OFS_SERVO_POS + 12'h010, SERVO_MIN_CYC);
		for (int l = 0; l < 15; l++) begin
			for (int c = 0; c < 8; c++) begin
				ma = (l < 8) ? OFS_MODE0 : OFS_MODE1;
				sh = 4 * (l % 8);
				pv = (c == 4) ? 1 : 4;
				ok = (c inside {0, 1, 4, 5}) || (c == 2 && SERVO_IN_LINES[l])
					|| (c == 3 && SERVO_OUT_LINES[l]) || (c == 6 && WAVE_OUT_LINES[l])
					|| (c == 7 && WAVE_IN_LINES[l]);
				apb(1'b1, ma, 32'(pv) << sh);
				apb(1'b1, ma, 32'(c) << sh);
				rdc("mode", ma, 32'(ok ? c : pv) << sh);
				if (c inside {0, 1, 4, 5}) begin
					cmp("oe_n", 32'(c != 1), {31'h0, line_oe_n[l]});
					cmp("pull", 32'(c == 5), {31'h0, pull_dn[l]});
				end
			end
		end
		apb(1'b1, OFS_MODE0, 32'h0000_5410);
		apb(1'b1, OFS_MODE1, 32'h0000_0010);
		apb(1'b1, OFS_LEVEL_OUT, 32'h7FFF);
		rdc("level out", OFS_LEVEL_OUT, 32'h7FFB);
		cmp("line1 high", 32'h1, {31'h0, line_out[1]});
		ext_drv <= 15'h7FF1;
		ext_val <= 15'h2A5B;
		apb(1'b0, OFS_LEVEL_IN, 32'h0);
		cmp("level in", 32'h2A53, rd_q & 32'h7FFB);
		apb(1'b1, OFS_LEVEL_OUT, 32'h0);
		@(posedge core_clk);
		cmp("line1 low", 32'h0, {31'h0, line_out[1]});
		apb(1'b0, 12'h0FC, 32'h0);
		cmp("unmapped", 32'h1, {31'h0, rd_err});
		apb(1'b1, OFS_SERVO_POS, 32'h1);
		cmp("servo in pos ro", 32'h1, {31'h0, rd_err});
		apb(1'b0, OFS_WAVE_PER + 12'h014, 32'h0);
		cmp("wave ch5", 32'h1, {31'h0, rd_err});
		ext_drv <= 15'h0000;
		apb(1'b1, OFS_MODE0, 32'h0);
		apb(1'b1, OFS_SERVO_EN, 32'h10);
		repeat (4) @(posedge core_clk);
		cmp("servo unconfigured", 32'h1, {30'h0, line_out[4], line_oe_n[4]});
		apb(1'b1, OFS_MODE0, 32'h0003_0000);
		repeat (4) @(posedge core_clk);
		cmp("servo pulse", 32'h2, {30'h0, line_out[4], line_oe_n[4]});
		apb(1'b1, OFS_SERVO_POS + 12'h010, 32'd200000);
		rdc("servo pos", OFS_SERVO_POS + 12'h010, 32'd200000);
		apb(1'b1, OFS_SERVO_EN, 32'h0);
		apb(1'b1, OFS_MODE0, 32'h0060_0000);
		apb(1'b1, OFS_WAVE_PER + 12'h004, 32'd10);
		apb(1'b1, OFS_WAVE_HIGH + 12'h004, 32'd3);
		apb(1'b1, OFS_WAVE_EN, 32'h200);
		{hi, lo} = 64'h0;
		while (line_out[5] !== 1'b1)
			@(posedge core_clk);
		while (line_out[5] !== 1'b0)
			@(posedge core_clk);
		while (line_out[5] !== 1'b1)
			@(posedge core_clk);
		while (line_out[5] === 1'b1) begin
			@(posedge core_clk);
			hi++;
		end
		while (line_out[5] === 1'b0) begin
			@(posedge core_clk);
			lo++;
		end
		cmp("wave high", 32'd3, 32'(hi));
		cmp("wave period", 32'd10, 32'(hi + lo));
		sq_en <= 1'b1;
		apb(1'b1, OFS_MODE0, 32'h0007_0000);
		apb(1'b1, OFS_WAVE_EN, 32'h1);
		repeat (100) @(posedge core_clk);
		rdc("wave meas period", OFS_WMEAS_PER, 32'd20);
		rdc("wave meas high", OFS_WMEAS_HIGH, 32'd7);
		ext_drv <= 15'h0001;
		ext_val <= 15'h0000;
		apb(1'b1, OFS_MODE0, 32'h0000_0002);
		apb(1'b1, OFS_SERVO_EN, 32'h1);
		ext_val <= 15'h0001;
		repeat (50) @(posedge core_clk);
		ext_val <= 15'h0000;
		repeat (4) @(posedge core_clk);
		rdc("servo in pos", OFS_SERVO_POS, 32'd50);
		end_of_test();
	end
endmodule // tb_top
`default_nettype wire
